/* src/walker_defs.svh */
// Purpose: Constants for the translation table walker.
// Assumes: 48-bit virtual and physical addresses, 64-bit descriptors.
// Notes: Included by the package and by the walker itself.
`ifndef WALKER_DEFS_SVH
`define WALKER_DEFS_SVH

// ----------------------------------------------------------------------
// Granules
// ----------------------------------------------------------------------
`define G4K 2'h0
`define G16K 2'h1
`define G64K 2'h3
`define OFF_4K 6'h0c
`define OFF_16K 6'h0e
`define OFF_64K 6'h10
`define BITS_4K 6'h09
`define BITS_16K 6'h0b
`define BITS_64K 6'h0d
`define FEAT_GRAN 3'h7
`define VA_FULL 7'h40
`define VA_MAX 7'h30

// ----------------------------------------------------------------------
// Descriptors, attributes and faults
// ----------------------------------------------------------------------
`define DT_BLOCK 2'h1
`define DT_TABLE 2'h3
`define LVL_LAST 2'h3
`define CACHE_WB_RWA 2'h3
`define SH_NON 2'h0
`define EL_HYP 2'h2
`define FK_DESC 2'h0
`define FK_RANGE 2'h1
`define FK_GRAN 2'h2
`define FK_FORMAT 2'h3

`endif

/* src/walker_pkg.sv */
// Purpose: Types shared by the translation table walker.
// Assumes: Constants come from walker_defs.svh.
// Notes: The whole walker state is one packed struct.
`include "walker_defs.svh"

package walker_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_ISSUE, ST_WAIT, ST_DONE} walk_state_t;

  typedef struct packed {
    logic tag_ignore;
    logic [1:0] kernel_granule_field;
    logic [1:0] user_granule_field;
    logic [5:0] kernel_size;
    logic [5:0] user_size;
  } translation_control_t;

  typedef struct packed {
    logic normal;
    logic [1:0] inner;
    logic [1:0] outer;
    logic [1:0] share;
    logic [2:0] index;
  } attr_t;

  typedef struct packed {
    logic [47:0] user_table_base;
    logic [47:0] kernel_table_base;
    translation_control_t tc;
    logic enable;
  } active_cfg_t;

  typedef struct packed {
    walk_state_t state;
    logic [47:0] va;
    logic [1:0] gran;
    logic [1:0] level;
    logic [47:0] taddr;
    logic [47:0] pa;
    logic fault;
    logic [1:0] fkind;
    logic translated;
    attr_t attr;
    active_cfg_t cfg;
  } walker_state_t;
endpackage

/* src/translation_table_walker.sv */
// Purpose: Stage 1 table walker turning virtual into physical addresses.
// Assumes: One clock; memory answers each read with one data beat.
// Notes: Table bases, translation control and enable are shadowed and only adopted at a sync barrier.
`timescale 1ns/1ns
`default_nettype none
`include "walker_defs.svh"

module translation_table_walker (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic [47:0] user_table_base_in,
  input wire logic [47:0] kernel_table_base_in,
  input wire walker_pkg::translation_control_t translation_control_in,
  input wire logic system_control_enable_in,
  input wire logic default_cacheable_bit_in,
  input wire logic context_sync_barrier_in,
  input wire logic nonsecure_in,
  input wire logic [1:0] exception_level_in,
  input wire logic legacy_short_format_in,
  input wire logic req_valid_in,
  input wire logic [63:0] req_va_in,
  output logic req_ready_out,
  output logic mem_req_valid_out,
  output logic [47:0] mem_addr_out,
  input wire logic mem_ready_in,
  input wire logic mem_valid_in,
  input wire logic [63:0] mem_data_in,
  output logic resp_valid_out,
  output logic [47:0] resp_pa_out,
  output logic resp_fault_out,
  output logic [1:0] resp_fault_kind_out,
  output logic resp_translated_out,
  output walker_pkg::attr_t resp_attr_out,
  output logic mmu_enabled_out,
  output logic [2:0] memory_feature_id_out
);

  // --------------------------------------------------------------------
  // Granule geometry
  // --------------------------------------------------------------------
  function automatic logic [5:0] gran_off(input logic [1:0] g);
    case (g)
      `G16K: gran_off = `OFF_16K;
      `G64K: gran_off = `OFF_64K;
      default: gran_off = `OFF_4K;
    endcase
  endfunction

  function automatic logic [5:0] gran_bits(input logic [1:0] g);
    case (g)
      `G16K: gran_bits = `BITS_16K;
      `G64K: gran_bits = `BITS_64K;
      default: gran_bits = `BITS_4K;
    endcase
  endfunction

  // Lowest address bit that a given level resolves.
  function automatic logic [5:0] lvl_shift(input logic [1:0] g, input logic [1:0] l);
    logic [5:0] steps;
    steps = {4'h0, 2'h3 - l};
    lvl_shift = gran_off(g) + gran_bits(g) * steps;
  endfunction

  function automatic logic [47:0] low_mask(input logic [5:0] sh);
    low_mask = ~({48{1'b1}} << sh);
  endfunction

  // Table base aligned to the granule, with the entry index in bits above 2.
  function automatic logic [47:0] entry_addr(input logic [47:0] base,
      input logic [47:0] va, input logic [1:0] g, input logic [1:0] l);
    logic [47:0] idx;
    idx = (va >> lvl_shift(g, l)) & low_mask(gran_bits(g));
    entry_addr = (base & ~low_mask(gran_off(g))) | (idx << 3);
  endfunction

  // A narrower range starts lower, because the top index would be empty.
  function automatic logic [1:0] start_level(input logic [1:0] g, input logic [6:0] inb);
    logic [6:0] o;
    logic [6:0] b;
    o = {1'b0, gran_off(g)};
    b = {1'b0, gran_bits(g)};
    if (inb > o + b * 7'h03) begin
      start_level = 2'h0;
    end else if (inb > o + b * 7'h02) begin
      start_level = 2'h1;
    end else if (inb > o + b) begin
      start_level = 2'h2;
    end else begin
      start_level = 2'h3;
    end
  endfunction

  // --------------------------------------------------------------------
  // Request decode
  // --------------------------------------------------------------------
  walker_pkg::walker_state_t s;
  walker_pkg::walker_state_t next_s;
  logic [15:0] top_bits;
  logic hi_ones;
  logic hi_zero;
  logic [5:0] tsz;
  logic [6:0] inbits;
  logic [47:0] range_mask;
  logic range_ok;
  logic [1:0] gran_raw;
  logic gran_ok;
  logic [47:0] va_idx;
  logic [1:0] slvl;
  logic [47:0] base;
  logic legacy_bad;
  walker_pkg::attr_t off_attr;
  logic [1:0] dtype;
  logic block_ok;
  logic [5:0] leaf_sh;
  logic [47:0] leaf_pa;
  // The feature set is named so that each granule bit can be selected on its own.
  localparam logic [2:0] granules_built = `FEAT_GRAN;

  // Tagging ignores the top byte and sign-extends from bit 55.
  assign top_bits = s.cfg.tc.tag_ignore ?
    {{8{req_va_in[55]}}, req_va_in[55:48]} : req_va_in[63:48];
  assign hi_ones = &top_bits;
  assign hi_zero = ~|top_bits;
  assign tsz = hi_ones ? s.cfg.tc.kernel_size : s.cfg.tc.user_size;
  assign gran_raw = hi_ones ? s.cfg.tc.kernel_granule_field
    : s.cfg.tc.user_granule_field;
  // Sizes below 16 would exceed 48 bits, so they clamp to the full range.
  assign inbits = (tsz < 6'h10) ? `VA_MAX : (`VA_FULL - {1'b0, tsz});
  assign range_mask = ~low_mask(inbits[5:0]);
  assign range_ok = (hi_ones || hi_zero) &&
    ((req_va_in[47:0] & range_mask) == (hi_ones ? range_mask : 48'h0));
  assign gran_ok = ((gran_raw == `G4K) && granules_built[0]) ||
    ((gran_raw == `G16K) && granules_built[1]) ||
    ((gran_raw == `G64K) && granules_built[2]);
  assign va_idx = req_va_in[47:0] & ~range_mask;
  assign slvl = start_level(gran_raw, inbits);
  assign base = hi_ones ? s.cfg.kernel_table_base : s.cfg.user_table_base;
  assign legacy_bad = legacy_short_format_in && (exception_level_in >= `EL_HYP);

  always_comb begin
    off_attr = '0;
    if (default_cacheable_bit_in && nonsecure_in && (exception_level_in < `EL_HYP)) begin
      off_attr.normal = 1'b1;
      off_attr.inner = `CACHE_WB_RWA;
      off_attr.outer = `CACHE_WB_RWA;
      off_attr.share = `SH_NON;
    end
  end

  // --------------------------------------------------------------------
  // Descriptor decode
  // --------------------------------------------------------------------
  assign dtype = mem_data_in[1:0];
  // Blocks exist only at 4KB level 1 and at level 2 of every granule.
  assign block_ok = (s.level == 2'h2) || ((s.level == 2'h1) && (s.gran == `G4K));
  assign leaf_sh = lvl_shift(s.gran, s.level);
  assign leaf_pa = (mem_data_in[47:0] & ~low_mask(leaf_sh)) |
    (s.va & low_mask(leaf_sh));

  // --------------------------------------------------------------------
  // Walk sequencer
  // --------------------------------------------------------------------
  always_comb begin
    next_s = s;
    // Shadowed copies make write order irrelevant until the barrier.
    if (context_sync_barrier_in) begin
      next_s.cfg.user_table_base = user_table_base_in;
      next_s.cfg.kernel_table_base = kernel_table_base_in;
      next_s.cfg.tc = translation_control_in;
      next_s.cfg.enable = system_control_enable_in;
    end
    case (s.state)
      walker_pkg::ST_IDLE: begin
        if (req_valid_in) begin
          next_s.va = va_idx;
          next_s.gran = gran_raw;
          next_s.level = slvl;
          next_s.fault = 1'b0;
          next_s.fkind = `FK_DESC;
          next_s.pa = 48'h0;
          next_s.attr = '0;
          // One snapshot of the enable per request: identity or full walk.
          next_s.translated = s.cfg.enable;
          next_s.state = walker_pkg::ST_DONE;
          if (!s.cfg.enable) begin
            next_s.pa = req_va_in[47:0];
            next_s.attr = off_attr;
          end else if (legacy_bad) begin
            next_s.fault = 1'b1;
            next_s.fkind = `FK_FORMAT;
          end else if (!range_ok) begin
            next_s.fault = 1'b1;
            next_s.fkind = `FK_RANGE;
          end else if (!gran_ok) begin
            next_s.fault = 1'b1;
            next_s.fkind = `FK_GRAN;
          end else begin
            next_s.taddr = entry_addr(base, va_idx, gran_raw, slvl);
            next_s.state = walker_pkg::ST_ISSUE;
          end
        end
      end
      walker_pkg::ST_ISSUE: begin
        if (mem_ready_in) begin
          next_s.state = walker_pkg::ST_WAIT;
        end
      end
      walker_pkg::ST_WAIT: begin
        if (mem_valid_in) begin
          next_s.state = walker_pkg::ST_DONE;
          if ((dtype == `DT_TABLE) && (s.level != `LVL_LAST)) begin
            next_s.level = s.level + 2'h1;
            next_s.taddr = entry_addr(mem_data_in[47:0], s.va, s.gran,
              s.level + 2'h1);
            next_s.state = walker_pkg::ST_ISSUE;
          end else if (((dtype == `DT_TABLE) && (s.level == `LVL_LAST)) ||
              ((dtype == `DT_BLOCK) && block_ok)) begin
            next_s.pa = leaf_pa;
            next_s.attr.normal = 1'b1;
            next_s.attr.index = mem_data_in[4:2];
          end else begin
            next_s.fault = 1'b1;
            next_s.fkind = `FK_DESC;
          end
        end
      end
      walker_pkg::ST_DONE: begin
        next_s.state = walker_pkg::ST_IDLE;
      end
      default: begin
        next_s.state = walker_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // --------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------
  assign req_ready_out = (s.state == walker_pkg::ST_IDLE);
  assign mem_req_valid_out = (s.state == walker_pkg::ST_ISSUE);
  assign resp_valid_out = (s.state == walker_pkg::ST_DONE);
  assign mem_addr_out = s.taddr;
  assign resp_pa_out = s.pa;
  assign resp_fault_out = s.fault;
  assign resp_fault_kind_out = s.fkind;
  assign resp_translated_out = s.translated;
  assign resp_attr_out = s.attr;
  assign mmu_enabled_out = s.cfg.enable;
  assign memory_feature_id_out = `FEAT_GRAN;

  // --------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!reset_n_in);

  sequence take_s;
    req_valid_in && req_ready_out;
  endsequence

  sequence take_on_s;
    take_s ##0 mmu_enabled_out;
  endsequence

  sequence leaf_beat_s;
    (s.state == walker_pkg::ST_WAIT) && mem_valid_in;
  endsequence

  sync_gate_a: assert property (!context_sync_barrier_in |=> $stable(mmu_enabled_out))
    else $error("enable changed without a barrier");

  enable_on_a: assert property (context_sync_barrier_in && system_control_enable_in
      |=> mmu_enabled_out)
    else $error("enable not adopted at barrier");

  identity_map_a: assert property (take_s ##0 !mmu_enabled_out |=> resp_valid_out &&
      !resp_translated_out && resp_pa_out == $past(req_va_in[47:0]))
    else $error("identity answer wrong");

  default_attr_a: assert property (take_s ##0 (!mmu_enabled_out &&
      default_cacheable_bit_in && nonsecure_in && exception_level_in < `EL_HYP)
      |=> resp_attr_out.normal && resp_attr_out.inner == `CACHE_WB_RWA &&
      resp_attr_out.outer == `CACHE_WB_RWA && resp_attr_out.share == `SH_NON)
    else $error("default attributes wrong");

  legacy_refuse_a: assert property (take_on_s ##0 legacy_bad
      |=> resp_valid_out && resp_fault_out && resp_fault_kind_out == `FK_FORMAT)
    else $error("legacy format accepted at high level");

  top_bits_a: assert property (take_on_s ##0 (!legacy_bad &&
      !s.cfg.tc.tag_ignore && !(&req_va_in[63:48]) && (|req_va_in[63:48]))
      |=> resp_fault_out && resp_fault_kind_out == `FK_RANGE)
    else $error("bad upper bits not faulted");

  level0_block_a: assert property (leaf_beat_s ##0 (s.level == 2'h0 &&
      dtype == `DT_BLOCK) |=> resp_valid_out && resp_fault_out)
    else $error("level 0 block accepted");

  level3_page_a: assert property (leaf_beat_s ##0 (s.level == `LVL_LAST &&
      dtype == `DT_TABLE) |=> resp_valid_out && !resp_fault_out ##1 req_ready_out)
    else $error("level 3 entry walked further");

  invalid_fault_a: assert property (leaf_beat_s ##0 !mem_data_in[0]
      |=> resp_valid_out && resp_fault_out && resp_fault_kind_out == `FK_DESC)
    else $error("invalid entry not faulted");

  walk_start_a: assert property (take_on_s ##0 (!legacy_bad && range_ok && gran_ok)
      |=> mem_req_valid_out && mem_addr_out[2:0] == 3'h0)
    else $error("walk did not start");

  sequence block_beat_s;
    leaf_beat_s ##0 ((dtype == `DT_BLOCK) && block_ok);
  endsequence

  // Block offsets pass straight through; the level and granule fix how many bits.
  block_1g_a: assert property (block_beat_s ##0 (s.level == 2'h1)
      |=> resp_pa_out[29:0] == s.va[29:0])
    else $error("1GB block offset wrong");

  block_32m_a: assert property (block_beat_s ##0 (s.level == 2'h2 && s.gran == `G16K)
      |=> resp_pa_out[24:0] == s.va[24:0])
    else $error("32MB block offset wrong");

  block_512m_a: assert property (block_beat_s ##0 (s.level == 2'h2 && s.gran == `G64K)
      |=> resp_pa_out[28:0] == s.va[28:0])
    else $error("512MB block offset wrong");

  table_step_a: assert property (leaf_beat_s ##0 (dtype == `DT_TABLE &&
      s.level != `LVL_LAST) |=> mem_req_valid_out && s.level == $past(s.level) + 2'h1)
    else $error("table entry did not descend");

  answer_end_a: assert property (resp_valid_out |=> !resp_valid_out && req_ready_out)
    else $error("answer held longer than one cycle");

endmodule
`default_nettype wire

/* tb/table_memory.sv */
// Purpose: Memory model that holds the translation tables read by the walker.
// Assumes: One read outstanding at a time; the bench fills table_mem.
// Notes: Ready and answer delay are random, so walks meet a random number of stalls, possibly none.
`timescale 1ns/1ns
`default_nettype none
module table_memory (
  input wire logic clk_in,
  input wire logic mem_req_valid_in,
  input wire logic [47:0] mem_addr_in,
  output logic mem_ready_out,
  output logic mem_valid_out,
  output logic [63:0] mem_data_out
);
  logic [63:0] table_mem [logic [47:0]];
  logic [47:0] addr = 48'h0;
  logic busy = 1'b0;
  int delay = 0;
  int n_reads = 0;
  integer seed = 32'h5a3c;

  initial begin
    mem_ready_out = 1'b0;
    mem_valid_out = 1'b0;
    mem_data_out = 64'h0;
  end

  always @(posedge clk_in) begin
    if (mem_ready_out && mem_req_valid_in) begin
      addr = mem_addr_in;
      busy = 1'b1;
      delay = $unsigned($random(seed)) % 4;
      n_reads++;
    end
  end

  // Between beats the data bus toggles, so a walker that samples it late reads garbage.
  always @(negedge clk_in) begin
    mem_valid_out <= 1'b0;
    mem_data_out <= ~mem_data_out;
    mem_ready_out <= !busy && (($random(seed) & 1) == 0);
    if (busy) begin
      if (delay == 0) begin
        mem_valid_out <= 1'b1;
        mem_data_out <= table_mem.exists(addr) ? table_mem[addr] : 64'h0;
        busy = 1'b0;
      end else begin
        delay--;
      end
    end
  end
endmodule
`default_nettype wire

/* tb/translation_table_walker_test.sv */
// Purpose: Self-checking bench for the translation table walker.
// Assumes: Inputs change on the falling edge; answers are caught on the rising edge.
// Notes: Table chains are built from random bases; expectations come from the index layout.
`timescale 1ns/1ns
`default_nettype none
module translation_table_walker_test;
  logic clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic [47:0] user_table_base_in = 48'h0;
  logic [47:0] kernel_table_base_in = 48'h0;
  walker_pkg::translation_control_t translation_control_in = '0;
  logic system_control_enable_in = 1'b0;
  logic default_cacheable_bit_in = 1'b0;
  logic context_sync_barrier_in = 1'b0;
  logic nonsecure_in = 1'b1;
  logic [1:0] exception_level_in = 2'h1;
  logic legacy_short_format_in = 1'b0;
  logic req_valid_in = 1'b0;
  logic [63:0] req_va_in = 64'h0;
  logic req_ready_out, mem_req_valid_out, mem_ready_in, mem_valid_in;
  logic resp_valid_out, resp_fault_out, resp_translated_out, mmu_enabled_out;
  logic [47:0] mem_addr_out, resp_pa_out, got_pa;
  logic [63:0] mem_data_in;
  logic [1:0] resp_fault_kind_out, got_kind;
  logic [2:0] memory_feature_id_out;
  logic got_fault, got_tr;
  walker_pkg::attr_t resp_attr_out, got_attr;
  int n_mismatch = 0;
  int comparisons = 0;
  int n_resp = 0;
  integer seed = 32'hd716;

  translation_table_walker i_translation_table_walker (.clk_in, .reset_n_in,
    .user_table_base_in, .kernel_table_base_in, .translation_control_in,
    .system_control_enable_in, .default_cacheable_bit_in, .context_sync_barrier_in,
    .nonsecure_in, .exception_level_in, .legacy_short_format_in, .req_valid_in, .req_va_in,
    .req_ready_out, .mem_req_valid_out, .mem_addr_out, .mem_ready_in, .mem_valid_in,
    .mem_data_in, .resp_valid_out, .resp_pa_out, .resp_fault_out, .resp_fault_kind_out,
    .resp_translated_out, .resp_attr_out, .mmu_enabled_out, .memory_feature_id_out);

  table_memory i_table_memory (.clk_in(clk_in), .mem_req_valid_in(mem_req_valid_out),
    .mem_addr_in(mem_addr_out), .mem_ready_out(mem_ready_in), .mem_valid_out(mem_valid_in),
    .mem_data_out(mem_data_in));

  initial begin
    forever #5 clk_in = ~clk_in;
  end

  always @(posedge clk_in) begin
    if (resp_valid_out === 1'b1) begin
      got_pa <= resp_pa_out;
      got_fault <= resp_fault_out;
      got_kind <= resp_fault_kind_out;
      got_tr <= resp_translated_out;
      got_attr <= resp_attr_out;
      n_resp <= n_resp + 1;
    end
  end

  task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic close_out();
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic configure(input logic en, input logic [1:0] ug, input logic [1:0] kg,
                           input logic [5:0] us, input logic [5:0] ks);
    // Control is synchronized first and the enable at the following barrier edge.
    @(negedge clk_in);
    translation_control_in = {1'b0, kg, ug, ks, us};
    context_sync_barrier_in = 1'b1;
    @(negedge clk_in);
    system_control_enable_in = en;
    @(negedge clk_in);
    context_sync_barrier_in = 1'b0;
    @(negedge clk_in);
    check("mmu_enabled", mmu_enabled_out, en);
  endtask

  task automatic request(input logic [63:0] v);
    int n;
    n = n_resp;
    @(negedge clk_in);
    check("req_ready", req_ready_out, 1'b1);
    req_va_in = v;
    req_valid_in = 1'b1;
    @(negedge clk_in);
    req_valid_in = 1'b0;
    for (int i = 0; i < 300 && n_resp == n; i++) @(negedge clk_in);
    check("responses", n_resp - n, 1);
  endtask

  // Builds a chain from the start level down to stop and checks reads and the answer.
  task automatic walk(input logic [1:0] g, input logic [5:0] sz, input logic k,
                      input int stop, input logic [1:0] ty);
    logic [63:0] v, d, idx;
    logic [47:0] t, pa;
    int off, bits, ins, lvl, low, w, r0;
    logic ok;
    off = g == 2'h0 ? 12 : g == 2'h1 ? 14 : 16;
    bits = off - 3;
    ins = 64 - sz;
    v = {$random(seed), $random(seed)};
    v = k ? v | ({64{1'b1}} << ins) : v & ~({64{1'b1}} << ins);
    lvl = 0;
    while (off + (3 - lvl) * bits >= ins) lvl++;
    if (stop < lvl) stop = lvl;
    configure(1'b1, k ? 2'h0 : g, k ? g : 2'h3, k ? 6'd16 : sz, k ? sz : 6'd22);
    i_table_memory.table_mem.delete();
    t = k ? kernel_table_base_in : user_table_base_in;
    for (int l = lvl; l <= stop; l++) begin
      low = off + (3 - l) * bits;
      w = ins - low < bits ? ins - low : bits;
      idx = (v >> low) & ((64'h1 << w) - 64'h1);
      d = {16'h0, $random(seed), 16'h3};
      if (l == stop) d[15:0] = 16'($random(seed)) & 16'hfffc | 16'(ty);
      i_table_memory.table_mem[t + idx[44:0] * 8] = d;
      t = {d[47:16], 16'h0};
      pa = (d[47:0] & ~((48'h1 << low) - 48'h1)) | (v[47:0] & ((48'h1 << low) - 48'h1));
    end
    ok = ty == 2'h3 ? stop == 3 : ty == 2'h1 && (stop == 2 || (stop == 1 && g == 2'h0));
    r0 = i_table_memory.n_reads;
    request(v);
    // A table entry at a stop level below 3 sends the walker one level further.
    check("reads", i_table_memory.n_reads - r0, stop - lvl + 1 + int'(ty == 2'h3 && stop < 3));
    check("fault", {got_fault, ok ? 2'h0 : got_kind}, {!ok, 2'h0});
    check("pa", got_pa, ok ? pa : 48'h0);
    if (ok) check("attr", got_attr, {1'b1, 6'h0, d[4:2]});
    check("translated", got_tr, 1'b1);
  endtask

  initial begin
    int g;
    user_table_base_in = {$random(seed), 16'h0};
    kernel_table_base_in = {$random(seed), 16'h0};
    repeat (12) @(negedge clk_in);
    reset_n_in = 1'b1;
    check("feature_id", memory_feature_id_out, 3'h7);
    default_cacheable_bit_in = 1'b1;
    system_control_enable_in = 1'b1;
    request(64'h0000_1234_5678_9abc);
    check("identity", {got_tr, got_pa}, 49'h0_1234_5678_9abc);
    check("default attr", got_attr[9:3], 7'h7c);
    default_cacheable_bit_in = 1'b0;
    request(64'h0000_0000_0000_4000);
    check("device attr", got_attr, 10'h0);
    default_cacheable_bit_in = 1'b1;
    nonsecure_in = 1'b0;
    request(64'h0000_0000_0000_8000);
    check("secure attr", got_attr, 10'h0);
    nonsecure_in = 1'b1;
    default_cacheable_bit_in = 1'b0;
    configure(1'b1, 2'h0, 2'h0, 6'd16, 6'd16);
    request(64'h0001_0000_0000_0000);
    check("range", {got_fault, got_kind}, 3'h5);
    exception_level_in = 2'h2;
    legacy_short_format_in = 1'b1;
    request(64'h0);
    check("legacy", {got_fault, got_kind}, 3'h7);
    legacy_short_format_in = 1'b0;
    exception_level_in = 2'h1;
    translation_control_in.tag_ignore = 1'b1;
    context_sync_barrier_in = 1'b1;
    @(negedge clk_in);
    context_sync_barrier_in = 1'b0;
    request(64'hab00_0000_0000_0000);
    check("tagged", {got_fault, got_kind}, 3'h4);
    configure(1'b1, 2'h2, 2'h0, 6'd16, 6'd16);
    request(64'h0);
    check("granule", {got_fault, got_kind}, 3'h6);
    walk(2'h0, 6'd16, 1'b0, 3, 2'h3);
    walk(2'h0, 6'd16, 1'b1, 1, 2'h1);
    walk(2'h0, 6'd16, 1'b0, 2, 2'h1);
    walk(2'h0, 6'd34, 1'b0, 3, 2'h3);
    walk(2'h0, 6'd16, 1'b0, 0, 2'h1);
    walk(2'h0, 6'd16, 1'b0, 3, 2'h1);
    walk(2'h0, 6'd16, 1'b1, 2, 2'h2);
    walk(2'h1, 6'd16, 1'b0, 3, 2'h3);
    walk(2'h1, 6'd16, 1'b1, 2, 2'h1);
    walk(2'h1, 6'd16, 1'b0, 1, 2'h1);
    walk(2'h1, 6'd22, 1'b0, 3, 2'h3);
    walk(2'h3, 6'd16, 1'b0, 3, 2'h3);
    walk(2'h3, 6'd22, 1'b1, 2, 2'h1);
    walk(2'h3, 6'd16, 1'b0, 1, 2'h1);
    for (int i = 0; i < 24; i++) begin
      g = $unsigned($random(seed)) % 3;
      walk(g == 2 ? 2'h3 : 2'(g), 6'(16 + $unsigned($random(seed)) % 10), 1'($random(seed)),
           3 - $unsigned($random(seed)) % 3, 2'($random(seed)));
    end
    close_out();
  end

  initial begin
    #400000;
    n_mismatch++;
    close_out();
  end
endmodule
`default_nettype wire
